// ---- design/dhp_host_ctrl.sv ----
// Host-side controller driving the dual-mode 16-bit host bus port.
// Assumes the device pins sit on the same board clock; ack input is synchronous.
// Summary of operation
// [RQ1] The device data path is 16 bits and runs either in generic split-strobe or address-strobe mode.
// [RQ2] Transfers are timed by a host bus clock that this block drives out, separate from the display clock.
// [RQ3] Chip select is asserted low by this block for every access to the device space.
// [RQ4] In generic mode a byte address goes out on address bits 0 to 16 with the word on data lines 0 to 15.
// [RQ5] In generic mode the low and high byte write enables go low while writing their lanes.
// [RQ6] In generic mode the low and high byte read enables go low while reading their lanes.
// [RQ7] In generic mode the device holds wait low until read data is ready or write data is taken.
// [RQ8] In generic mode the bus status line is held low as it only selects the mode.
// [RQ9] In address-strobe mode a word address goes on bits 1 to 16 and bit 0 carries the lower data strobe.
// [RQ10] In address-strobe mode lower and upper data strobes go low to enable their lanes for both directions.
// [RQ11] In address-strobe mode the direction line is low for a write and high for a read.
// [RQ12] In address-strobe mode the bus status line low marks a valid address.
// [RQ13] In address-strobe mode the wait line acts as transfer acknowledge, low when data is ready or taken.
// [RQ14] In address-strobe mode the separate low byte write and read enables are held high.
// [RQ15] The endian strap pin selects little or big byte order at device reset.
// [RQ16] The device latches mode straps and bus status at the rising edge of its reset and keeps them.
// [RQ17] With chip select high the data lines are left undriven and wait is ignored.
module dhp_host_ctrl #(
  parameter int ADDR_W      = dhp_pkg::ADDR_W,
  parameter int DATA_W      = dhp_pkg::DATA_W,
  parameter int DEV_RST_CYC = dhp_pkg::DEV_RST_CYC,
  parameter int TIMEOUT_CYC = dhp_pkg::TIMEOUT_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  // Strap selection, captured once after reset
  input  wire logic              cfg_addr_strobe_mode,
  input  wire logic              cfg_big_endian,
  // User command and response
  input  wire logic              cmd_valid,
  input  wire logic              cmd_write,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [1:0]        cmd_byte_en,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  output logic                   cmd_ready,
  output logic                   rsp_valid,
  output logic                   rsp_timeout,
  output logic [DATA_W-1:0]      rsp_rdata,
  // Device pins
  output logic                   dev_reset_n,
  output logic                   host_bus_clock,
  output logic [2:0]             mode_config_pins,
  output logic                   endian_config_pin,
  output logic                   chip_select_n,
  output logic [ADDR_W-1:0]      host_addr_in,
  output logic [DATA_W-1:0]      host_data_out,
  output logic                   host_data_oe,
  input  wire logic [DATA_W-1:0] host_data_in,
  output logic                   low_byte_write_en_n,
  output logic                   high_byte_enable_n,
  output logic                   low_byte_read_en_n,
  output logic                   read_write_n,
  output logic                   bus_status_n,
  input  wire logic              transfer_ack_n
);

  // ==========================================================
  // Strobe decode: {low write, high write/upper strobe, low read, rd-wr}
  function automatic logic [3:0] lane_strobes(
    input logic       as_mode,
    input logic       wr,
    input logic [1:0] be,
    input logic       on
  );
    logic [3:0] s;
    s = {1'b1, 1'b1, 1'b1, ~wr};
    if (as_mode) begin
      s = {1'b1, ~(on & be[1]), 1'b1, ~wr}; // RQ10 RQ11 RQ14
    end else if (wr) begin
      s = {~(on & be[0]), ~(on & be[1]), 1'b1, 1'b1}; // RQ5
    end else begin
      s = {1'b1, 1'b1, ~(on & be[0]), ~(on & be[1])}; // RQ6
    end
    return s;
  endfunction : lane_strobes

  // ==========================================================
  // State
  dhp_pkg::dhp_state_t      state_q, state_d;
  logic [dhp_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic                      cap_q;
  logic                      as_mode_q;
  logic                      big_q;
  logic                      wr_q;
  logic [ADDR_W-1:0]         addr_q;
  logic [1:0]                be_q;
  logic [DATA_W-1:0]         wdata_q;
  logic                      clk_div_q;

  wire cmd_load  = (state_q == dhp_pkg::ST_IDLE) && cmd_valid;
  wire wr_sel    = cmd_load ? cmd_write : wr_q;
  wire [ADDR_W-1:0] addr_sel = cmd_load ? cmd_addr : addr_q;
  wire [1:0] be_sel = cmd_load ? cmd_byte_en : be_q;
  // Generic wait high means done; address-strobe ack low means done
  wire ack_seen  = as_mode_q ? ~transfer_ack_n : transfer_ack_n; // RQ7 RQ13
  wire strobe_ok = cnt_q >= dhp_pkg::CNT_W'(dhp_pkg::STROBE_MIN_CYC - 1);
  wire timed_out = cnt_q >= dhp_pkg::CNT_W'(TIMEOUT_CYC - 1);
  wire done      = (state_q == dhp_pkg::ST_STROBE) && ((strobe_ok && ack_seen) || timed_out);

  // ==========================================================
  // Sequencer
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + 1'b1;
    unique case (state_q)
      dhp_pkg::ST_RESET: begin
        if (cap_q && cnt_q >= dhp_pkg::CNT_W'(DEV_RST_CYC - 1)) begin
          state_d = dhp_pkg::ST_IDLE;
        end
      end
      dhp_pkg::ST_IDLE: begin
        cnt_d = '0;
        if (cmd_valid) begin
          state_d = dhp_pkg::ST_SETUP;
        end
      end
      dhp_pkg::ST_SETUP: begin
        if (cnt_q >= dhp_pkg::CNT_W'(dhp_pkg::SETUP_CYC - 1)) begin
          state_d = dhp_pkg::ST_STROBE;
          cnt_d   = '0;
        end
      end
      dhp_pkg::ST_STROBE: begin
        if (done) begin
          state_d = dhp_pkg::ST_HOLD;
        end
      end
      dhp_pkg::ST_HOLD: begin
        state_d = dhp_pkg::ST_RECOVER;
        cnt_d   = '0;
      end
      dhp_pkg::ST_RECOVER: begin
        if (cnt_q >= dhp_pkg::CNT_W'(dhp_pkg::RECOVER_CYC - 1)) begin
          state_d = dhp_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = dhp_pkg::ST_RESET;
        cnt_d   = '0;
      end
    endcase
  end

  // ==========================================================
  // Pin values for the coming cycle
  wire       n_rst     = state_d == dhp_pkg::ST_RESET;
  wire       n_sel     = (state_d == dhp_pkg::ST_SETUP) || (state_d == dhp_pkg::ST_STROBE) ||
                         (state_d == dhp_pkg::ST_HOLD);
  wire       n_strb    = state_d == dhp_pkg::ST_STROBE;
  wire [3:0] n_lanes   = lane_strobes(as_mode_q, wr_sel, n_sel ? be_sel : dhp_pkg::BE_NONE, n_strb);
  // Address-strobe mode puts the lower strobe on bit 0 instead of a byte address
  wire       n_addr0   = as_mode_q ? ~(n_strb & be_sel[0]) : addr_sel[0]; // RQ4 RQ9
  // Bus status stays low in generic mode so the strap reads generic
  wire       n_bs_n    = as_mode_q ? ~n_sel : 1'b0; // RQ8 RQ12 RQ16
  wire       n_oe      = n_sel && wr_sel; // RQ17
  wire [2:0] n_cnf     = as_mode_q ? dhp_pkg::CNF_ADDR_STROBE : dhp_pkg::CNF_GENERIC; // RQ1
  // Data is zero whenever it is not driven
  wire [DATA_W-1:0] n_wdata = n_oe ? (cmd_load ? cmd_wdata : wdata_q) : '0;
  wire       n_timeout = done && !(strobe_ok && ack_seen);
  // Lane strobes by pin
  wire       n_lo_wr_n = n_lanes[3];
  wire       n_hi_en_n = n_lanes[2];
  wire       n_lo_rd_n = n_lanes[1];
  wire       n_rw_n    = n_lanes[0];

  // ==========================================================
  // Registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= dhp_pkg::ST_RESET;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // ==========================================================
  // Bus clock divider
  // Free running; the sequencer never waits on its phase
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_div_q <= 1'b0;
    end else begin
      clk_div_q <= ~clk_div_q; // RQ2
    end
  end

  // Straps taken in the first cycle after release, never under reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cap_q     <= 1'b0;
      as_mode_q <= 1'b0;
      big_q     <= dhp_pkg::ENDIAN_LITTLE;
    end else if (!cap_q) begin
      cap_q     <= 1'b1;
      as_mode_q <= cfg_addr_strobe_mode;
      big_q     <= cfg_big_endian ? dhp_pkg::ENDIAN_BIG : dhp_pkg::ENDIAN_LITTLE; // RQ15
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q    <= 1'b0;
      addr_q  <= '0;
      be_q    <= dhp_pkg::BE_NONE;
      wdata_q <= '0;
    end else if (cmd_load) begin
      wr_q    <= cmd_write;
      addr_q  <= cmd_addr;
      be_q    <= cmd_byte_en;
      wdata_q <= cmd_wdata;
    end
  end

  // ==========================================================
  // Device reset and straps
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dev_reset_n       <= 1'b0;
      mode_config_pins  <= dhp_pkg::RST_CNF;
      endian_config_pin <= dhp_pkg::ENDIAN_LITTLE;
    end else begin
      // Straps stay driven after release so the device sees them at the edge
      dev_reset_n       <= ~n_rst; // RQ16
      mode_config_pins  <= n_cnf;
      endian_config_pin <= big_q; // RQ15
    end
  end

  // ==========================================================
  // Select, address and data
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      chip_select_n <= 1'b1;
      host_addr_in  <= '0;
      host_data_out <= '0;
      host_data_oe  <= 1'b0;
      bus_status_n  <= 1'b0;
    end else begin
      chip_select_n <= ~n_sel; // RQ3
      host_addr_in  <= {addr_sel[ADDR_W-1:1], n_addr0};
      host_data_out <= n_wdata;
      host_data_oe  <= n_oe;
      bus_status_n  <= n_bs_n;
    end
  end

  // ==========================================================
  // Byte lane strobes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_byte_write_en_n <= 1'b1;
      high_byte_enable_n  <= 1'b1;
      low_byte_read_en_n  <= 1'b1;
      read_write_n        <= 1'b1;
    end else begin
      low_byte_write_en_n <= n_lo_wr_n;
      high_byte_enable_n  <= n_hi_en_n;
      low_byte_read_en_n  <= n_lo_rd_n;
      read_write_n        <= n_rw_n;
    end
  end

  // ==========================================================
  // Host bus clock
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      host_bus_clock <= 1'b0;
    end else begin
      host_bus_clock <= clk_div_q; // RQ2
    end
  end

  // ==========================================================
  // User response
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_ready   <= 1'b0;
      rsp_valid   <= 1'b0;
      rsp_timeout <= 1'b0;
    end else begin
      cmd_ready   <= state_d == dhp_pkg::ST_IDLE;
      rsp_valid   <= done;
      rsp_timeout <= n_timeout;
    end
  end

  // Read data holds until the next read completes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_rdata <= '0;
    end else if (done && !wr_q) begin
      rsp_rdata <= host_data_in; // RQ7 RQ13
    end
  end

endmodule : dhp_host_ctrl

// ---- design/dhp_pkg.sv ----
// Constants and types for the dual-mode host bus port controller.
// Assumes a 100 MHz sys_clk; all times are converted to cycles here.
package dhp_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam int CNT_W  = 16;

  // ==========================================================
  // Timing
  localparam int SYS_CLK_NS    = 10;
  localparam int DEV_RST_NS    = 1000;
  localparam int SETUP_NS      = 20;
  localparam int STROBE_MIN_NS = 30;
  localparam int RECOVER_NS    = 20;
  localparam int TIMEOUT_NS    = 10000;
  // Least times round up, the timeout is a longest time and rounds down
  localparam int DEV_RST_CYC    = (DEV_RST_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int SETUP_CYC      = (SETUP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int STROBE_MIN_CYC = (STROBE_MIN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int RECOVER_CYC    = (RECOVER_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int TIMEOUT_CYC    = TIMEOUT_NS / SYS_CLK_NS;

  // ==========================================================
  // Configuration straps
  localparam logic [2:0] CNF_ADDR_STROBE = 3'h3;
  localparam logic [2:0] CNF_GENERIC     = 3'h7;
  localparam logic       ENDIAN_LITTLE   = 1'h0;
  localparam logic       ENDIAN_BIG      = 1'h1;

  // ==========================================================
  // Reset values
  localparam logic [2:0] RST_CNF    = 3'h7;
  localparam logic [1:0] BE_NONE    = 2'h0;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_RESET   = 3'h0,
    ST_IDLE    = 3'h1,
    ST_SETUP   = 3'h2,
    ST_STROBE  = 3'h3,
    ST_HOLD    = 3'h4,
    ST_RECOVER = 3'h5
  } dhp_state_t;

endpackage : dhp_pkg

// ---- tb/dhp_host_ctrl_asserts.sv ----
// Checker on the device-side pins of the host port controller.
// Assumes a bind onto dhp_host_ctrl and one clock domain.
module dhp_host_ctrl_asserts #(
  parameter int TIMEOUT_CYC = 20
) (
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        rsp_valid,
  input wire logic [2:0]  mode_config_pins,
  input wire logic        chip_select_n,
  input wire logic [16:0] host_addr_in,
  input wire logic        host_data_oe,
  input wire logic        low_byte_write_en_n,
  input wire logic        high_byte_enable_n,
  input wire logic        low_byte_read_en_n,
  input wire logic        read_write_n,
  input wire logic        bus_status_n
);
  // ====
  // Decode
  localparam int MAX_WAIT = TIMEOUT_CYC + 8;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire gen_m = (mode_config_pins == dhp_pkg::CNF_GENERIC);
  wire as_m  = (mode_config_pins == dhp_pkg::CNF_ADDR_STROBE);
  wire g_wr  = gen_m && (!low_byte_write_en_n || !high_byte_enable_n);
  wire g_rd  = gen_m && (!low_byte_read_en_n || !read_write_n);
  wire on    = g_wr || g_rd || (as_m && (!host_addr_in[0] || !high_byte_enable_n));
  sequence s_take;
    $fell(chip_select_n);
  endsequence
  sequence s_finish;
    rsp_valid ##1 (chip_select_n && !host_data_oe);
  endsequence
  // ====
  // Properties
  strobe_setup_a: assert property (s_take |-> ##2 on) else $error("strobe not on after setup");
  access_bound_a: assert property (s_take |-> ##[5:MAX_WAIT] rsp_valid) else $error("access not ended");
  release_bus_a: assert property (rsp_valid |-> s_finish) else $error("bus not released");
  idle_quiet_a: assert property (chip_select_n |-> !host_data_oe && !on) else $error("drive while idle");
  gen_write_a: assert property (g_wr |-> host_data_oe && low_byte_read_en_n && read_write_n)
    else $error("bad write lanes");
  gen_read_a: assert property (g_rd |-> !host_data_oe && low_byte_write_en_n && high_byte_enable_n)
    else $error("bad read lanes");
  gen_status_a: assert property (gen_m |-> !bus_status_n) else $error("status high in generic");
  as_unused_a: assert property (as_m && $stable(mode_config_pins) |-> low_byte_write_en_n && low_byte_read_en_n)
    else $error("unused enable low");
  as_valid_a: assert property (as_m && $stable(mode_config_pins) |-> bus_status_n == chip_select_n)
    else $error("status not with select");
  as_direction_a: assert property (as_m && $stable(mode_config_pins) && !chip_select_n |->
    read_write_n == !host_data_oe) else $error("direction wrong");
endmodule : dhp_host_ctrl_asserts

bind dhp_host_ctrl dhp_host_ctrl_asserts #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_asserts (.sys_clk, .reset_n, .rsp_valid,
  .mode_config_pins, .chip_select_n, .host_addr_in, .host_data_oe, .low_byte_write_en_n, .high_byte_enable_n,
  .low_byte_read_en_n, .read_write_n, .bus_status_n);

// ---- tb/dhp_dev_model.sv ----
// Behavioural display controller host port, sixteen words deep.
// Assumes lat bus clocks of wait per access; no byte swap modelled.
module dhp_dev_model (
  input  wire logic        dev_reset_n,
  input  wire logic        host_bus_clock,
  input  wire logic [2:0]  mode_config_pins,
  input  wire logic        chip_select_n,
  input  wire logic [16:0] host_addr_in,
  input  wire logic [15:0] host_data_out,
  output logic      [15:0] host_data_in,
  input  wire logic        low_byte_write_en_n,
  input  wire logic        high_byte_enable_n,
  input  wire logic        low_byte_read_en_n,
  input  wire logic        read_write_n,
  input  wire logic        bus_status_n,
  output logic             transfer_ack_n,
  input  wire logic [7:0]  lat
);
  // ====
  // Port logic
  logic        as_q;
  logic [7:0]  cnt_q;
  logic [15:0] last_q;
  logic [15:0] mem_q [16];
  always_ff @(posedge dev_reset_n) as_q <= (mode_config_pins == dhp_pkg::CNF_ADDR_STROBE);
  wire       sel  = !chip_select_n && (!as_q || !bus_status_n);
  wire       lo_w = as_q ? !read_write_n && !host_addr_in[0] : !low_byte_write_en_n;
  wire       hi_w = as_q ? !read_write_n && !high_byte_enable_n : !high_byte_enable_n;
  wire       lo_r = as_q ? read_write_n && !host_addr_in[0] : !low_byte_read_en_n;
  wire       hi_r = as_q ? read_write_n && !high_byte_enable_n : !read_write_n;
  wire       act  = sel && (lo_w || hi_w || lo_r || hi_r);
  wire       done = act && (cnt_q >= lat);
  wire [3:0] idx  = host_addr_in[4:1];
  // Released bus flips every clock so a stale value never passes
  assign host_data_in   = (act && (lo_r || hi_r)) ? mem_q[idx] : ~last_q;
  assign transfer_ack_n = as_q ? !done : !(act && !done);
  always_ff @(posedge host_bus_clock or negedge dev_reset_n) begin
    if (!dev_reset_n) begin
      cnt_q  <= 8'h00;
      last_q <= 16'h0000;
    end else begin
      cnt_q  <= !act ? 8'h00 : (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
      last_q <= host_data_in;
      if (act && lo_w) mem_q[idx][7:0] <= host_data_out[7:0];
      if (act && hi_w) mem_q[idx][15:8] <= host_data_out[15:8];
    end
  end
endmodule : dhp_dev_model

// ---- tb/dhp_host_ctrl_tb.sv ----
// Self-checking bench: controller against the device model.
// Assumes package, design, model and checker compiled first.
module dhp_host_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 0, reset_n = 0, cfg_addr_strobe_mode = 0, cfg_big_endian = 0, cmd_valid = 0;
  logic        cmd_write = 0, cmd_ready, rsp_valid, rsp_timeout, dev_reset_n, host_bus_clock, to_v;
  logic        endian_config_pin, chip_select_n, host_data_oe, low_byte_write_en_n, high_byte_enable_n;
  logic        low_byte_read_en_n, read_write_n, bus_status_n, transfer_ack_n;
  logic [1:0]  cmd_byte_en = 0;
  logic [2:0]  mode_config_pins;
  logic [7:0]  lat = 0;
  logic [16:0] cmd_addr = 0, host_addr_in;
  logic [15:0] cmd_wdata = 0, rsp_rdata, host_data_out, host_data_in, rd_v;
  int          miscompares = 0, cmp_count = 0, cycles = 0;
  wire         bus_clk_dly;

  dhp_host_ctrl #(.DEV_RST_CYC(4), .TIMEOUT_CYC(20)) dut (.sys_clk, .reset_n, .cfg_addr_strobe_mode,
    .cfg_big_endian, .cmd_valid, .cmd_write, .cmd_addr, .cmd_byte_en, .cmd_wdata, .cmd_ready, .rsp_valid,
    .rsp_timeout, .rsp_rdata, .dev_reset_n, .host_bus_clock, .mode_config_pins, .endian_config_pin,
    .chip_select_n, .host_addr_in, .host_data_out, .host_data_oe, .host_data_in, .low_byte_write_en_n,
    .high_byte_enable_n, .low_byte_read_en_n, .read_write_n, .bus_status_n, .transfer_ack_n);
  dhp_dev_model u_dev (.dev_reset_n, .host_bus_clock(bus_clk_dly), .mode_config_pins, .chip_select_n, .host_addr_in,
    .host_data_out, .host_data_in, .low_byte_write_en_n, .high_byte_enable_n, .low_byte_read_en_n,
    .read_write_n, .bus_status_n, .transfer_ack_n, .lat);

  always #5 sys_clk = ~sys_clk;
  // Board delay keeps the model off the edge that launches the pins
  assign #2 bus_clk_dly = host_bus_clock;
  // Ceiling far above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  // ====
  // Tasks
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wait_ready();
    while (cmd_ready !== 1'b1) begin
      @(posedge sys_clk);
      #1;
    end
  endtask : wait_ready
  task automatic apply_reset(input logic as_m, input logic big);
    reset_n = 0;
    cfg_addr_strobe_mode = as_m;
    cfg_big_endian = big;
    repeat (3) @(posedge sys_clk);
    #1 reset_n = 1;
    wait_ready();
    chk("mode pins", {13'h0, as_m ? dhp_pkg::CNF_ADDR_STROBE : dhp_pkg::CNF_GENERIC}, {13'h0, mode_config_pins});
    chk("endian pin", {15'h0, big}, {15'h0, endian_config_pin});
  endtask : apply_reset
  task automatic access(input logic wr, input logic [16:0] a, input logic [1:0] be, input logic [15:0] d);
    wait_ready();
    {cmd_valid, cmd_write, cmd_addr, cmd_byte_en, cmd_wdata} = {1'b1, wr, a, be, d};
    @(posedge sys_clk);
    #1 cmd_valid = 0;
    while (rsp_valid !== 1'b1) begin
      @(posedge sys_clk);
      #1;
    end
    rd_v = rsp_rdata;
    to_v = rsp_timeout;
  endtask : access
  task automatic t_generic();
    apply_reset(1'b0, 1'b0);
    lat = 8'h03;
    access(1'b1, 17'h0000A, 2'h3, 16'hA5C3);
    access(1'b0, 17'h0000A, 2'h3, 16'h0000);
    chk("generic word", 16'hA5C3, rd_v);
    access(1'b1, 17'h0000A, 2'h1, 16'hFF12);
    access(1'b1, 17'h0000A, 2'h2, 16'h34FF);
    access(1'b0, 17'h0000A, 2'h1, 16'h0000);
    chk("generic lanes", 16'h0012, {8'h00, rd_v[7:0]});
    chk("generic flag", 16'h0000, {15'h0, to_v});
    access(1'b0, 17'h0000A, 2'h2, 16'h0000);
    chk("generic high", 16'h3400, {rd_v[15:8], 8'h00});
  endtask : t_generic
  task automatic t_timeout();
    lat = 8'hFF;
    access(1'b0, 17'h00004, 2'h3, 16'h0000);
    chk("wait held flag", 16'h0001, {15'h0, to_v});
  endtask : t_timeout
  task automatic t_addr_strobe();
    apply_reset(1'b1, 1'b1);
    lat = 8'h00;
    access(1'b1, 17'h1FFFE, 2'h3, 16'h5A69);
    access(1'b1, 17'h1FFFE, 2'h2, 16'hC3FF);
    access(1'b1, 17'h1FFFE, 2'h1, 16'hFF00);
    lat = 8'h04;
    access(1'b0, 17'h1FFFE, 2'h3, 16'h0000);
    chk("strobe word", 16'hC300, rd_v);
    chk("strobe flag", 16'h0000, {15'h0, to_v});
  endtask : t_addr_strobe
  initial begin
    t_generic();
    t_timeout();
    t_addr_strobe();
    print_verdict();
  end
endmodule : dhp_host_ctrl_tb
